// ===== hw/icmr_top.sv
// Purpose: Control, priority, request and mask registers of irq unit
// Assumes: Inputs synchronous to sys_clk; ext pins active low
// Notes:   Standby gates wake-up and, with bit 14 set and the pin low, nmi detection; registers are kept through it
//
// The address-and-strobe port and the register addresses were left to the implementer.
`include "icmr_map.svh"
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Control register resets, kept through standby
// - Bit 15 reads live pin level
// - Bit 14: pin low masks all maskable
// - Standby, bit 14 set, pin low: no interrupt, no wake
// - Bit 9: nmi detected while blocked
// - Nmi acceptance clears bit 9
// - Bit 8 picks nmi active edge
// - Bit 7 picks external pin encoding
// - Reserved control bits read zero
// - Priority register resets zero, upper half zero
// - Priority nibbles: timer4, timer3, pci1, pci0
// - Level 15 highest, level 0 masks
// - Request register shows raw requests
// - Request bit one while pending
// - Mask resets to all ten masked
// - Mask one blocks, zero passes
// - Writing zero to mask keeps it
// - Clear register ones release masks
// - Shared bit map, ten sources
// - Forward winner above cpu mask level
module icmr_top (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  input  wire logic              nmi_pin,
  input  wire logic [3:0]        ext_priority_pins,
  input  wire logic [9:0]        src_req,
  input  wire logic              cpu_exception_block_bit,
  input  wire icmr_pkg::icmr_lvl_t cpu_imask,
  input  wire logic              standby_mode,
  input  wire logic              nmi_ack,
  output logic                   nmi_req,
  output logic                   irq_req,
  output icmr_pkg::icmr_lvl_t    irq_level,
  output logic [3:0]             irq_src,
  output logic                   standby_wake
);
  import icmr_pkg::*;

  icmr_state_t st_r;
  icmr_state_t st_nxt;

  function automatic icmr_lvl_t src_lvl(input logic [15:0] pri,
                                        input int i);
    icmr_lvl_t l;
    l = pri[3:0];
    if (i == 9) begin
      l = pri[15:12];
    end else if (i == 8) begin
      l = pri[11:8];
    end else if (i >= 1) begin
      l = pri[7:4];
    end
    return l;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Decode and masking terms
  logic      sel_ctrl;
  logic      sel_pri;
  logic      sel_req;
  logic      sel_msk;
  logic      sel_clr;
  logic      mask_all;
  logic      nmi_edge;
  logic [9:0] elig;
  icmr_lvl_t ext_lvl;

  assign sel_ctrl = (reg_addr == `ICMR_OFS_CTRL);
  assign sel_pri  = (reg_addr == `ICMR_OFS_PRI);
  assign sel_req  = (reg_addr == `ICMR_OFS_REQ);
  assign sel_msk  = (reg_addr == `ICMR_OFS_MSK);
  assign sel_clr  = (reg_addr == `ICMR_OFS_CLR);

  assign mask_all = st_r.mask_all_while_nmi_low & ~nmi_pin;
  assign nmi_edge = st_r.prev_ok &
                    (st_r.nmi_edge_select ? (nmi_pin & ~st_r.nmi_prev)
                               : (~nmi_pin & st_r.nmi_prev));

  genvar g;
  generate
    for (g = 0; g < 10; g++) begin : g_elig
      // Raw request passes when unmasked and level nonzero
      assign elig[g] = st_r.req[g] & ~st_r.msk[g] &
                       (src_lvl(st_r.pri, g) != 4'h0);
    end
  endgenerate

  always_comb begin
    ext_lvl = 4'h0;
    if (!st_r.ext_pin_encoding_mode) begin
      ext_lvl = ~ext_priority_pins;
    end else if (!ext_priority_pins[0]) begin
      ext_lvl = `ICMR_IRL0_LVL;
    end else if (!ext_priority_pins[1]) begin
      ext_lvl = `ICMR_IRL1_LVL;
    end else if (!ext_priority_pins[2]) begin
      ext_lvl = `ICMR_IRL2_LVL;
    end else if (!ext_priority_pins[3]) begin
      ext_lvl = `ICMR_IRL3_LVL;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    icmr_lvl_t  best_l;
    logic [3:0] best_s;
    icmr_lvl_t  l;
    best_l = ext_lvl;
    best_s = (ext_lvl != 4'h0) ? `ICMR_EXT_ID : `ICMR_NONE_ID;
    l = 4'h0;
    st_nxt = st_r;
    st_nxt.req      = src_req;
    st_nxt.nmi_prev = nmi_pin;
    st_nxt.prev_ok  = 1'b1;
    // Priority pick, lower index wins a tie
    for (int i = 9; i >= 0; i--) begin
      l = src_lvl(st_r.pri, i);
      if (elig[i] && l >= best_l) begin
        best_l = l;
        best_s = 4'(i);
      end
    end
    st_nxt.lvl = best_l;
    st_nxt.src = best_s;
    st_nxt.irq = !mask_all && best_s != `ICMR_NONE_ID &&
                 best_l > cpu_imask;
    if (nmi_ack) begin
      st_nxt.nmi_pend = 1'b0;
    end
    if (nmi_edge && !(standby_mode && mask_all)) begin
      st_nxt.nmi_pend = 1'b1;
    end
    if (reg_wr) begin
      if (sel_ctrl) begin
        st_nxt.mask_all_while_nmi_low  = reg_wdata[`ICMR_B_MAI];
        st_nxt.nmi_detect_while_blocked = reg_wdata[`ICMR_B_NMI_DETECT_WHILE_BLOCKED];
        st_nxt.nmi_edge_select = reg_wdata[`ICMR_B_NMI_EDGE_SELECT];
        st_nxt.ext_pin_encoding_mode = reg_wdata[`ICMR_B_EXT_PIN_ENCODING_MODE];
      end else if (sel_pri) begin
        st_nxt.pri = reg_wdata[15:0];
      end else if (sel_msk) begin
        st_nxt.msk = st_r.msk | reg_wdata[9:0];
      end else if (sel_clr) begin
        st_nxt.msk = st_r.msk & ~reg_wdata[9:0];
      end
    end
    if (nmi_ack) begin
      st_nxt.nmi_detect_while_blocked = 1'b0;
    end
    st_nxt.rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (sel_ctrl) begin
        st_nxt.rdata[`ICMR_B_LVL]  = nmi_pin;
        st_nxt.rdata[`ICMR_B_MAI]  = st_r.mask_all_while_nmi_low;
        st_nxt.rdata[`ICMR_B_NMI_DETECT_WHILE_BLOCKED] = st_r.nmi_detect_while_blocked;
        st_nxt.rdata[`ICMR_B_NMI_EDGE_SELECT] = st_r.nmi_edge_select;
        st_nxt.rdata[`ICMR_B_EXT_PIN_ENCODING_MODE] = st_r.ext_pin_encoding_mode;
      end else if (sel_pri) begin
        st_nxt.rdata[15:0] = st_r.pri;
      end else if (sel_req) begin
        st_nxt.rdata[9:0] = st_r.req;
      end else if (sel_msk) begin
        st_nxt.rdata[9:0] = st_r.msk;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r          <= '0;
      st_r.pri      <= `ICMR_PRI_RST;
      st_r.req      <= `ICMR_REQ_RST;
      st_r.msk      <= `ICMR_MSK_RST;
      st_r.nmi_prev <= 1'b1;
      st_r.src      <= `ICMR_NONE_ID;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = st_r.rdata;
  assign irq_req   = st_r.irq;
  assign irq_level = st_r.lvl;
  assign irq_src   = st_r.src;
  assign nmi_req   = st_r.nmi_pend &
                     (!cpu_exception_block_bit || st_r.nmi_detect_while_blocked);
  assign standby_wake = standby_mode && !mask_all &&
                        (nmi_req || irq_req);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_ctrl_rd;
    reg_rd && sel_ctrl;
  endsequence
  sequence s_fall;
    !st_r.nmi_edge_select && st_r.prev_ok && st_r.nmi_prev && !nmi_pin &&
    !(standby_mode && mask_all);
  endsequence

  chk_pin_level: assert property (s_ctrl_rd |=>
    reg_rdata[15] == $past(nmi_pin))
    else $error("pin level bit wrong");
  chk_ctrl_resvd: assert property (s_ctrl_rd |=>
    reg_rdata[13:10] == 4'h0 && reg_rdata[6:0] == 7'h00 &&
    reg_rdata[31:16] == 16'h0000)
    else $error("reserved control bits not zero");
  chk_mai_block: assert property (st_r.mask_all_while_nmi_low && !nmi_pin |=>
    !irq_req)
    else $error("maskable irq passed with pin low");
  chk_standby_nowake: assert property (
    standby_mode && st_r.mask_all_while_nmi_low && !nmi_pin |-> !standby_wake)
    else $error("standby woke with pin low");
  chk_nmi_detect_while_blocked_clear: assert property (nmi_ack |=> !st_r.nmi_detect_while_blocked)
    else $error("block detect bit not cleared");
  chk_fall_edge: assert property (s_fall |=> st_r.nmi_pend)
    else $error("falling edge missed");
  chk_rise_edge: assert property (st_r.nmi_edge_select && st_r.prev_ok &&
    !st_r.nmi_prev && nmi_pin && !(standby_mode && mask_all) |=>
    st_r.nmi_pend)
    else $error("rising edge missed");
  chk_rdata_idle: assert property (!$past(reg_rd) |->
    reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read");
  chk_pri_upper: assert property (reg_rd && sel_pri |=>
    reg_rdata[31:16] == 16'h0000 && reg_rdata[15:0] == $past(st_r.pri))
    else $error("priority readback wrong");
  chk_req_raw: assert property (reg_rd && sel_req |=>
    reg_rdata[9:0] == $past(src_req, 2))
    else $error("request readback not raw");
  chk_mask_set: assert property (reg_wr && sel_msk |=>
    st_r.msk == ($past(st_r.msk) | $past(reg_wdata[9:0])))
    else $error("mask write wrong");
  chk_mask_clear: assert property (reg_wr && sel_clr |=>
    (st_r.msk & $past(reg_wdata[9:0])) == 10'h000)
    else $error("mask clear failed");
  chk_fwd_level: assert property (irq_req |->
    irq_level > $past(cpu_imask) && irq_level != 4'h0)
    else $error("forwarded level not above mask");
endmodule

`default_nettype wire

// ===== hw/icmr_map.svh
// Purpose: Offsets, field positions and reset values of the irq block
// Assumes: Byte addresses on an 8-bit register port
// Notes:   Definitions only
`ifndef ICMR_MAP_SVH
`define ICMR_MAP_SVH
`define ICMR_OFS_CTRL    8'h00
`define ICMR_OFS_PRI     8'h04
`define ICMR_OFS_REQ     8'h08
`define ICMR_OFS_MSK     8'h0c
`define ICMR_OFS_CLR     8'h10
`define ICMR_B_LVL       15
`define ICMR_B_MAI       14
`define ICMR_B_NMI_DETECT_WHILE_BLOCKED      9
`define ICMR_B_NMI_EDGE_SELECT      8
`define ICMR_B_EXT_PIN_ENCODING_MODE      7
`define ICMR_PRI_RST     16'h0000
`define ICMR_MSK_RST     10'h3ff
`define ICMR_REQ_RST     10'h000
`define ICMR_IRL0_LVL    4'hd
`define ICMR_IRL1_LVL    4'ha
`define ICMR_IRL2_LVL    4'h7
`define ICMR_IRL3_LVL    4'h4
`define ICMR_EXT_ID      4'ha
`define ICMR_NONE_ID     4'hf
`endif

// ===== hw/icmr_pkg.sv
// Purpose: Types of the irq control and mask block
// Assumes: Ten peripheral sources
// Notes:   Constants live in icmr_map.svh
package icmr_pkg;
  typedef logic [3:0] icmr_lvl_t;
  typedef struct packed {
    logic        mask_all_while_nmi_low;
    logic        nmi_detect_while_blocked;
    logic        nmi_edge_select;
    logic        ext_pin_encoding_mode;
    logic [15:0] pri;
    logic [9:0]  req;
    logic [9:0]  msk;
    logic        prev_ok;
    logic        nmi_prev;
    logic        nmi_pend;
    logic [31:0] rdata;
    logic        irq;
    icmr_lvl_t   lvl;
    logic [3:0]  src;
  } icmr_state_t;
endpackage

// ===== test/icmr_cpu_model.sv
// Purpose: Cpu side model that takes nmi requests
// Assumes: Ack is a one-cycle pulse
// Notes:   ACK_DLY sets how slowly the cpu answers
`timescale 1ns/10ps
`default_nettype none
module icmr_cpu_model #(
  parameter int ACK_DLY = 0
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       nmi_req,
  output logic            nmi_ack,
  output logic [7:0]      nmi_taken
);
  logic [7:0] wait_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wait_r    <= 8'h00;
      nmi_ack   <= 1'b0;
      nmi_taken <= 8'h00;
    end else if (nmi_ack) begin
      nmi_ack <= 1'b0;
      wait_r  <= 8'h00;
    end else if (nmi_req && wait_r == 8'(ACK_DLY)) begin
      nmi_ack   <= 1'b1;
      nmi_taken <= nmi_taken + 8'h01;
    end else if (nmi_req) begin
      wait_r <= wait_r + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Purpose: Register and arbitration tests of the irq block
// Assumes: Cpu model acks nmi after a few cycles
// Notes:   Register port per bench protocol
`include "icmr_map.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import icmr_pkg::*;
  logic        sys_clk = 0;
  logic        resetn = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 0;
  logic        reg_rd = 0;
  logic        nmi_pin = 1;
  logic [3:0]  ext_pins = 4'hf;
  logic [9:0]  src_req = 10'h000;
  logic        blk = 0;
  logic        standby_mode = 0;
  icmr_lvl_t   cpu_imask = 4'h0;
  logic [31:0] reg_rdata;
  logic        nmi_ack, nmi_req, irq_req, standby_wake;
  icmr_lvl_t   irq_level;
  logic [3:0]  irq_src;
  logic [7:0]  nmi_taken;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #20 sys_clk = ~sys_clk;
  icmr_top DUT (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .nmi_pin(nmi_pin), .ext_priority_pins(ext_pins),
    .src_req(src_req), .cpu_exception_block_bit(blk), .cpu_imask(cpu_imask),
    .standby_mode(standby_mode), .nmi_ack(nmi_ack), .nmi_req(nmi_req),
    .irq_req(irq_req), .irq_level(irq_level), .irq_src(irq_src),
    .standby_wake(standby_wake));
  icmr_cpu_model #(.ACK_DLY(3)) cpu (.sys_clk(sys_clk), .resetn(resetn),
    .nmi_req(nmi_req), .nmi_ack(nmi_ack), .nmi_taken(nmi_taken));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string n);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(n, e, reg_rdata);
    @(posedge sys_clk);
  endtask
  task automatic irq(input logic r, input logic [3:0] l, s);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("irq_req", 32'(r), 32'(irq_req));
    if (r) begin
      chk("irq_level", 32'(l), 32'(irq_level));
      chk("irq_src", 32'(s), 32'(irq_src));
    end
    @(posedge sys_clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(`ICMR_OFS_CTRL, 32'h0000_8000, "ctrl");
    rd(`ICMR_OFS_PRI, 32'h0000_0000, "pri");
    rd(`ICMR_OFS_REQ, 32'h0000_0000, "req");
    rd(`ICMR_OFS_MSK, 32'h0000_03ff, "msk");
    $display("test reset done");
    wr(`ICMR_OFS_CTRL, 32'hffff_ffff);
    rd(`ICMR_OFS_CTRL, 32'h0000_c380, "ctrl");
    wr(`ICMR_OFS_CTRL, 32'h0000_0000);
    wr(`ICMR_OFS_PRI, 32'hffff_3960);
    rd(`ICMR_OFS_PRI, 32'h0000_3960, "pri");
    wr(`ICMR_OFS_MSK, 32'h0000_0000);
    rd(`ICMR_OFS_MSK, 32'h0000_03ff, "msk");
    wr(`ICMR_OFS_CLR, 32'h0000_0001);
    rd(`ICMR_OFS_MSK, 32'h0000_03fe, "msk");
    wr(`ICMR_OFS_MSK, 32'hffff_fc01);
    rd(`ICMR_OFS_MSK, 32'h0000_03ff, "msk");
    rd(8'h20, 32'h0000_0000, "unmapped");
    $display("test registers done");
    @(posedge sys_clk);
    src_req <= 10'h381;
    rd(`ICMR_OFS_REQ, 32'h0000_0381, "req");
    irq(0, 0, 0);
    wr(`ICMR_OFS_CLR, 32'h0000_03ff);
    irq(1, 9, 8);
    cpu_imask <= 4'h9;
    irq(0, 0, 0);
    cpu_imask <= 4'h8;
    irq(1, 9, 8);
    wr(`ICMR_OFS_MSK, 32'h0000_0100);
    cpu_imask <= 4'h0;
    irq(1, 6, 7);
    wr(`ICMR_OFS_PRI, 32'h0000_3900);
    irq(1, 3, 9);
    $display("test arbitration done");
    wr(`ICMR_OFS_CTRL, 32'h0000_4000);
    nmi_pin <= 1'b0;
    irq(0, 0, 0);
    rd(`ICMR_OFS_CTRL, 32'h0000_4000, "ctrl");
    repeat (6) @(posedge sys_clk);
    chk("nmi_taken", 32'h0000_0001, 32'(nmi_taken));
    standby_mode <= 1'b1;
    irq(0, 0, 0);
    @(negedge sys_clk);
    chk("standby_wake", 32'h0000_0000, 32'(standby_wake));
    @(posedge sys_clk);
    nmi_pin      <= 1'b1;
    irq(1, 3, 9);
    @(negedge sys_clk);
    chk("standby_wake", 32'h0000_0001, 32'(standby_wake));
    @(posedge sys_clk);
    standby_mode <= 1'b0;
    wr(`ICMR_OFS_CTRL, 32'h0000_0100);
    nmi_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("nmi_taken", 32'h0000_0001, 32'(nmi_taken));
    nmi_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("nmi_taken", 32'h0000_0002, 32'(nmi_taken));
    blk <= 1'b1;
    wr(`ICMR_OFS_CTRL, 32'h0000_0000);
    nmi_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("nmi_taken", 32'h0000_0002, 32'(nmi_taken));
    wr(`ICMR_OFS_CTRL, 32'h0000_0200);
    repeat (8) @(posedge sys_clk);
    chk("nmi_taken", 32'h0000_0003, 32'(nmi_taken));
    rd(`ICMR_OFS_CTRL, 32'h0000_0000, "ctrl");
    blk <= 1'b0;
    $display("test nmi done");
    wr(`ICMR_OFS_MSK, 32'h0000_03ff);
    ext_pins <= 4'ha;
    irq(1, 5, 10);
    wr(`ICMR_OFS_CTRL, 32'h0000_0080);
    ext_pins <= 4'he;
    irq(1, 13, 10);
    $display("test pins done");
    complete_run();
  end
endmodule
`default_nettype wire
